// file: verilog/odc_cmd_exec.sv
// serial command execution for an octal voltage-output converter
`timescale 1ns/10ps
`default_nettype none
module odc_cmd_exec import odc_pkg::*; (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // serial link pins
    input wire logic i_frame_sel_n,
    input wire logic i_sclk,
    input wire logic i_serial_in,
    input wire logic i_output_load_strobe_n,
    // serial output pin
    output logic o_serial_out,
    output logic o_serial_out_oe,
    // channel outputs
    output logic [NUM_CH*DATA_W-1:0] o_out_code,
    output logic [NUM_CH-1:0] o_pwrdn_mode_hi,
    output logic [NUM_CH-1:0] o_pwrdn_mode_lo,
    output logic [NUM_CH-1:0] o_out_hiz,
    output logic [NUM_CH-1:0] o_out_gnd_1k,
    output logic o_chain_enable
);
    typedef enum logic [1:0] {ODC_IDLE, ODC_SHIFT} odc_state_t;

    function automatic logic [NUM_CH-1:0] odc_onehot(input logic [3:0] addr);
        logic [NUM_CH-1:0] v;
        v = '0;
        if (addr < 4'(NUM_CH)) begin
            v[addr[2:0]] = 1'b1;
        end
        return v;
    endfunction : odc_onehot

    logic fs_lvl;
    logic fs_rise;
    logic fs_fall;
    logic sck_rise;
    logic sck_fall;
    logic sdi_lvl;
    logic stb_lvl;
    logic stb_fall;

    odc_sync u_fs (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_frame_sel_n),
        .o_level(fs_lvl),
        .o_rise(fs_rise),
        .o_fall(fs_fall)
    );
    odc_sync u_sck (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_sclk),
        .o_level(),
        .o_rise(sck_rise),
        .o_fall(sck_fall)
    );
    odc_sync u_sdi (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_serial_in),
        .o_level(sdi_lvl),
        .o_rise(),
        .o_fall()
    );
    odc_sync u_stb (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_output_load_strobe_n),
        .o_level(stb_lvl),
        .o_rise(),
        .o_fall(stb_fall)
    );

    // link state
    odc_state_t state;
    odc_state_t next_state;
    logic [FRAME_BITS-1:0] shreg;
    logic [FRAME_BITS-1:0] next_shreg;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic overflow;
    logic next_overflow;
    logic serial_out;
    logic next_sdo;
    logic [FRAME_BITS-1:0] rb_shreg;
    logic [FRAME_BITS-1:0] next_rb_shreg;
    logic rb_armed;
    logic next_rb_armed;
    logic rb_active;
    logic next_rb_active;
    logic [3:0] rb_addr;
    logic [3:0] next_rb_addr;
    // register state
    logic [DATA_W-1:0] in_reg [NUM_CH];
    logic [DATA_W-1:0] next_in_reg [NUM_CH];
    logic [DATA_W-1:0] out_reg [NUM_CH];
    logic [DATA_W-1:0] next_out_reg [NUM_CH];
    logic [2*NUM_CH-1:0] pwr;
    logic [2*NUM_CH-1:0] next_pwr;
    logic [NUM_CH-1:0] stb_mask;
    logic [NUM_CH-1:0] next_stb_mask;
    logic chain_en;
    logic next_chain_en;

    logic [3:0] f_cmd;
    logic [3:0] f_addr;
    logic [DATA_W-1:0] f_data;
    logic [NUM_CH-1:0] f_sel;
    logic [DATA_W-1:0] rb_word;

    assign f_cmd = shreg[CMD_MSB:CMD_LSB];
    assign f_addr = shreg[ADDR_MSB:ADDR_LSB];
    assign f_data = shreg[DATA_MSB:0];
    assign f_sel = odc_onehot(f_addr);
    assign rb_word = in_reg[rb_addr[2:0]];

    // serial capture and serial output
    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bit_cnt = bit_cnt;
        next_overflow = overflow;
        next_sdo = serial_out;
        next_rb_shreg = rb_shreg;
        next_rb_armed = rb_armed;
        next_rb_active = rb_active;
        next_rb_addr = rb_addr;
        case (state)
            ODC_IDLE: begin
                if (fs_fall) begin
                    next_state = ODC_SHIFT;
                    next_bit_cnt = BIT_CNT_RESET;
                    next_overflow = 1'b0;
                    next_rb_active = rb_armed;
                    next_rb_armed = 1'b0;
                    next_rb_shreg = {{RB_UNDEF_BITS{1'b0}}, rb_word, 4'h0};
                end
            end
            ODC_SHIFT: begin
                if (fs_rise) begin
                    next_state = ODC_IDLE;
                    next_rb_active = 1'b0;
                    if (f_cmd == CMD_READBACK) begin
                        next_rb_armed = 1'b1;
                        next_rb_addr = f_addr;
                    end
                end else begin
                    if (sck_fall) begin
                        next_shreg = {shreg[FRAME_BITS-2:0], sdi_lvl};
                        if (bit_cnt == 5'(FRAME_BITS - 1)) begin
                            next_overflow = 1'b1;
                        end
                        if (bit_cnt != BIT_CNT_MAX) begin
                            next_bit_cnt = bit_cnt + 5'h1;
                        end
                    end
                    if (sck_rise) begin
                        if (rb_active) begin
                            next_sdo = rb_shreg[FRAME_BITS-1];
                            next_rb_shreg = {rb_shreg[FRAME_BITS-2:0], 1'b0};
                        end else if (chain_en && (overflow || bit_cnt != BIT_CNT_RESET)) begin
                            next_sdo = shreg[FRAME_BITS-1];
                        end
                    end
                end
            end
            default: next_state = ODC_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state <= ODC_IDLE;
            shreg <= '0;
            bit_cnt <= BIT_CNT_RESET;
            overflow <= 1'b0;
            serial_out <= 1'b0;
            rb_shreg <= '0;
            rb_armed <= 1'b0;
            rb_active <= 1'b0;
            rb_addr <= 4'h0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bit_cnt <= next_bit_cnt;
            overflow <= next_overflow;
            serial_out <= next_sdo;
            rb_shreg <= next_rb_shreg;
            rb_armed <= next_rb_armed;
            rb_active <= next_rb_active;
            rb_addr <= next_rb_addr;
        end
    end

    // command execution and load strobe
    always_comb begin
        next_in_reg = in_reg;
        next_out_reg = out_reg;
        next_pwr = pwr;
        next_stb_mask = stb_mask;
        next_chain_en = chain_en;
        if (stb_fall) begin
            for (int k = 0; k < NUM_CH; k++) begin
                if (!stb_mask[k]) begin
                    next_out_reg[k] = in_reg[k];
                end
            end
        end
        if (state == ODC_SHIFT && fs_rise) begin
            case (f_cmd)
                CMD_WR_INPUT: begin
                    for (int k = 0; k < NUM_CH; k++) begin
                        if (f_sel[k]) begin
                            next_in_reg[k] = f_data;
                            if (!stb_lvl && !stb_mask[k]) begin
                                next_out_reg[k] = f_data;
                            end
                        end
                    end
                end
                CMD_UPD_OUT: begin
                    for (int k = 0; k < NUM_CH; k++) begin
                        if (f_data[k]) begin
                            next_out_reg[k] = in_reg[k];
                        end
                    end
                end
                CMD_WR_UPD: begin
                    for (int k = 0; k < NUM_CH; k++) begin
                        if (f_sel[k]) begin
                            next_in_reg[k] = f_data;
                            next_out_reg[k] = f_data;
                        end
                    end
                end
                CMD_PWRDN: next_pwr = f_data;
                CMD_STB_MASK: next_stb_mask = f_data[NUM_CH-1:0];
                CMD_CHAIN: next_chain_en = f_data[0];
                CMD_NOP, CMD_NOP_CHAIN: ;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            for (int k = 0; k < NUM_CH; k++) begin
                in_reg[k] <= CODE_RESET;
                out_reg[k] <= CODE_RESET;
            end
            pwr <= PWR_RESET;
            stb_mask <= MASK_RESET;
            chain_en <= CHAIN_RESET;
        end else begin
            in_reg <= next_in_reg;
            out_reg <= next_out_reg;
            pwr <= next_pwr;
            stb_mask <= next_stb_mask;
            chain_en <= next_chain_en;
        end
    end

    // outputs
    always_comb begin
        for (int k = 0; k < NUM_CH; k++) begin
            o_out_code[k*DATA_W +: DATA_W] = out_reg[k];
            o_pwrdn_mode_hi[k] = pwr[2*k+1];
            o_pwrdn_mode_lo[k] = pwr[2*k];
            o_out_hiz[k] = (pwr[2*k+1 -: 2] == PWR_HIZ);
            o_out_gnd_1k[k] = (pwr[2*k+1 -: 2] == PWR_1K_GND);
        end
    end

    assign o_serial_out = serial_out;
    assign o_serial_out_oe = (chain_en || rb_active) && !fs_lvl;
    assign o_chain_enable = chain_en;
endmodule : odc_cmd_exec
`default_nettype wire

// file: verilog/odc_pkg.sv
// constants for the octal converter command execution block
package odc_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int NUM_CH = 8;
    localparam int DATA_W = 16;
    localparam int RB_UNDEF_BITS = 4;
    localparam int LINK_CLK_PERIOD_NS = 400;
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WR_INPUT = 4'h1;
    localparam logic [3:0] CMD_UPD_OUT = 4'h2;
    localparam logic [3:0] CMD_WR_UPD = 4'h3;
    localparam logic [3:0] CMD_PWRDN = 4'h4;
    localparam logic [3:0] CMD_STB_MASK = 4'h5;
    localparam logic [3:0] CMD_CHAIN = 4'h8;
    localparam logic [3:0] CMD_READBACK = 4'h9;
    localparam logic [3:0] CMD_NOP_CHAIN = 4'hF;
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_1K_GND = 2'h1;
    localparam logic [1:0] PWR_HIZ = 2'h3;
    localparam logic CHAIN_RESET = 1'b0;
    localparam logic [4:0] BIT_CNT_RESET = 5'h0;
    localparam logic [4:0] BIT_CNT_MAX = 5'h1F;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [15:0] PWR_RESET = 16'h0000;
    localparam logic [15:0] CODE_RESET = 16'h0000;
endpackage : odc_pkg

// file: verilog/odc_sync.sv
// two flip-flop synchroniser with edge outputs
`timescale 1ns/10ps
`default_nettype none
module odc_sync (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // asynchronous level in
    input wire logic i_async,
    // synchronised level and edges
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic meta;
    logic stage;
    logic prev;
    logic next_meta;
    logic next_stage;
    logic next_prev;

    always_comb begin
        next_meta = i_async;
        next_stage = meta;
        next_prev = stage;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            meta <= 1'b1;
            stage <= 1'b1;
            prev <= 1'b1;
        end else begin
            meta <= next_meta;
            stage <= next_stage;
            prev <= next_prev;
        end
    end

    assign o_level = stage;
    assign o_rise = stage & ~prev;
    assign o_fall = ~stage & prev;
endmodule : odc_sync
`default_nettype wire

// file: test/odc_cmd_exec_props.sv
// assertion checker for the command execution block
`timescale 1ns/10ps
`default_nettype none
module odc_cmd_exec_props import odc_pkg::*; (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // link pins
    input wire logic i_frame_sel_n,
    input wire logic i_sclk,
    input wire logic i_serial_in,
    input wire logic i_output_load_strobe_n,
    // outputs
    input wire logic o_serial_out,
    input wire logic o_serial_out_oe,
    input wire logic [NUM_CH*DATA_W-1:0] o_out_code,
    input wire logic [NUM_CH-1:0] o_pwrdn_mode_hi,
    input wire logic [NUM_CH-1:0] o_pwrdn_mode_lo,
    input wire logic [NUM_CH-1:0] o_out_hiz,
    input wire logic [NUM_CH-1:0] o_out_gnd_1k,
    input wire logic o_chain_enable
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    property p_rst_val; $rose(i_rst_n) |-> !o_chain_enable && o_out_code == '0; endproperty
    a_rst_val: assert property (p_rst_val) else $error("bad reset value");
    property p_oe_idle; i_frame_sel_n [*4] |-> !o_serial_out_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("out enable idle");
    property p_hold; i_frame_sel_n [*4] |=> $stable(o_serial_out); endproperty
    a_hold: assert property (p_hold) else $error("out moved idle");
    property p_sclk_hi; i_sclk [*8] |=> $stable(o_serial_out); endproperty
    a_sclk_hi: assert property (p_sclk_hi) else $error("out moved sclk high");
    property p_hiz; o_out_hiz == (o_pwrdn_mode_hi & o_pwrdn_mode_lo); endproperty
    a_hiz: assert property (p_hiz) else $error("hiz decode");
    property p_gnd; o_out_gnd_1k == (~o_pwrdn_mode_hi & o_pwrdn_mode_lo); endproperty
    a_gnd: assert property (p_gnd) else $error("gnd decode");
    property p_chain; $changed(o_chain_enable) |-> $past(i_frame_sel_n, 3); endproperty
    a_chain: assert property (p_chain) else $error("chain mid frame");
    property p_upd;
        $changed({o_out_code, o_pwrdn_mode_hi, o_pwrdn_mode_lo}) |-> $past(i_frame_sel_n, 3);
    endproperty
    a_upd: assert property (p_upd) else $error("update mid frame");
endmodule : odc_cmd_exec_props
bind odc_cmd_exec odc_cmd_exec_props i_props (.i_core_clk, .i_rst_n, .i_frame_sel_n,
    .i_sclk, .i_serial_in, .i_output_load_strobe_n, .o_serial_out, .o_serial_out_oe,
    .o_out_code, .o_pwrdn_mode_hi, .o_pwrdn_mode_lo, .o_out_hiz, .o_out_gnd_1k,
    .o_chain_enable);
`default_nettype wire

// file: test/odc_host_model.sv
// host serial controller model
`timescale 1ns/10ps
`default_nettype none
module odc_host_model (
    // clock
    input wire logic i_core_clk,
    // serial out pin
    input wire logic i_serial_out,
    input wire logic i_serial_out_oe,
    // serial pins driven
    output logic o_frame_sel_n,
    output logic o_sclk,
    output logic o_serial_in
);
    logic keep = 1'b0;
    wire line = i_serial_out_oe ? i_serial_out : keep;
    // weak keeper holds last bit
    always @(posedge i_core_clk) if (i_serial_out_oe) keep <= i_serial_out;
    initial begin
        o_frame_sel_n = 1'b1;
        o_sclk = 1'b1;
        o_serial_in = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : tick
    task automatic send(input logic [47:0] w, input int nb, output logic [47:0] rx);
        rx = '0;
        o_serial_in = w[nb-1];
        o_frame_sel_n = 1'b0;
        tick(4);
        // gated burst of exactly nb clocks
        for (int i = nb - 1; i >= 0; i--) begin
            o_sclk = 1'b0;
            tick(3);
            o_sclk = 1'b1;
            tick(1);
            o_serial_in = w[i == 0 ? 0 : i - 1];
            tick(4);
            rx[i] = line;
        end
        o_frame_sel_n = 1'b1;
        tick(8);
    endtask : send
endmodule : odc_host_model
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench for the command execution block
`timescale 1ns/10ps
`default_nettype none
module tb_top import odc_pkg::*;;
    typedef struct {int k; logic [127:0] e;} odc_note_t;
    logic clk = 0, rst_n = 0, fs_n, sclk, serial_in, stb_n = 1, so, oe, chain;
    logic [127:0] code;
    logic [7:0] hi, lo, e_hi, e_lo, msk = 0;
    logic [7:0] hz, g1k, e_hz, e_g;
    logic [15:0] ein [8], eout [8], d;
    logic [47:0] rx, w;
    int seed = 76952, miscompares = 0, checks = 0;
    odc_note_t q[$];
    event ev;
    initial forever #25 clk = ~clk;
    odc_cmd_exec i_odc_cmd_exec (.i_core_clk(clk), .i_rst_n(rst_n), .i_frame_sel_n(fs_n),
        .i_sclk(sclk), .i_serial_in(serial_in), .i_output_load_strobe_n(stb_n), .o_serial_out(so),
        .o_serial_out_oe(oe), .o_out_code(code), .o_pwrdn_mode_hi(hi), .o_pwrdn_mode_lo(lo),
        .o_out_hiz(hz), .o_out_gnd_1k(g1k), .o_chain_enable(chain));
    odc_host_model i_odc_host_model (.i_core_clk(clk), .i_serial_out(so),
        .i_serial_out_oe(oe), .o_frame_sel_n(fs_n), .o_sclk(sclk), .o_serial_in(serial_in));
    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic cmp(input logic [127:0] e, input logic [127:0] a);
        checks++;
        if (a !== e) begin
            miscompares++;
            $display("[FAIL] %0t exp %h got %h", $time, e, a);
        end
    endtask : cmp
    task automatic cmp_code(input logic [127:0] e);
        cmp(e, code);
    endtask : cmp_code
    task automatic cmp_pwr(input logic [127:0] e);
        cmp(e, 128'({hi, lo}));
    endtask : cmp_pwr
    task automatic cmp_chain(input logic [127:0] e);
        cmp(e, 128'(chain));
    endtask : cmp_chain
    task automatic cmp_rbk(input logic [127:0] e);
        cmp(e, 128'(rx[19:4]));
    endtask : cmp_rbk
    task automatic cmp_dchain(input logic [127:0] e);
        cmp(e, 128'(rx[24:1]));
    endtask : cmp_dchain
    task automatic cmp_decode(input logic [127:0] e);
        cmp(e, 128'({hz, g1k}));
    endtask : cmp_decode
    task automatic chk(input int k, input logic [127:0] e);
        q.push_back('{k, e});
        ->ev;
    endtask : chk
    task automatic chk_out();
        logic [127:0] e;
        for (int k = 0; k < NUM_CH; k++) e[16*k+:16] = eout[k];
        chk(0, e);
    endtask : chk_out
    // compares all pending notes
    always @(ev) begin
        odc_note_t n;
        while (q.size() > 0) begin
            n = q.pop_front();
            case (n.k)
                0: cmp_code(n.e);
                1: cmp_pwr(n.e);
                2: cmp_chain(n.e);
                3: cmp_rbk(n.e);
                5: cmp_decode(n.e);
                default: cmp_dchain(n.e);
            endcase
        end
    end
    task automatic frx(input logic [47:0] f, input int nb);
        logic [3:0] c;
        logic [2:0] a;
        c = f[23:20];
        a = f[18:16];
        i_odc_host_model.send(f, nb, rx);
        if (c == CMD_WR_INPUT || c == CMD_WR_UPD) ein[a] = f[15:0];
        if (c == CMD_WR_UPD || (c == CMD_WR_INPUT && !stb_n && !msk[a])) eout[a] = f[15:0];
        if (c == CMD_UPD_OUT) for (int k = 0; k < NUM_CH; k++) if (f[k]) eout[k] = ein[k];
        if (c == CMD_STB_MASK) msk = f[7:0];
    endtask : frx
    task automatic fr(input logic [3:0] c, input logic [3:0] a, input logic [15:0] v);
        frx({24'h0, c, a, v}, 24);
    endtask : fr
    task automatic strobe();
        stb_n = 1'b0;
        for (int k = 0; k < NUM_CH; k++) if (!msk[k]) eout[k] = ein[k];
        tick(6);
        stb_n = 1'b1;
        tick(6);
    endtask : strobe
    initial begin
        #2ms;
        miscompares++;
        stop_test();
    end
    initial begin
        for (int k = 0; k < NUM_CH; k++) {ein[k], eout[k]} = 32'h0;
        tick(8);
        rst_n = 1'b1;
        tick(5);
        chk(2, 128'h0);
        fr(CMD_NOP, 4'h1, 16'hFFFF);
        fr(CMD_NOP_CHAIN, 4'h2, 16'hFFFF);
        chk_out();
        for (int k = 0; k < NUM_CH; k++) fr(CMD_WR_UPD, 4'(k), 16'($random(seed)));
        chk_out();
        fr(CMD_WR_INPUT, 4'h2, 16'($random(seed)));
        chk_out();
        fr(CMD_READBACK, 4'h2, 16'hFFFF);
        fr(CMD_NOP, 4'h0, 16'h0000);
        chk(3, 128'(ein[2]));
        strobe();
        chk_out();
        fr(CMD_STB_MASK, 4'h0, 16'h0004);
        fr(CMD_WR_INPUT, 4'h2, 16'($random(seed)));
        strobe();
        chk_out();
        stb_n = 1'b0;
        tick(6);
        fr(CMD_WR_INPUT, 4'h3, 16'($random(seed)));
        chk_out();
        stb_n = 1'b1;
        fr(CMD_WR_INPUT, 4'h5, 16'($random(seed)));
        fr(CMD_WR_INPUT, 4'h6, 16'($random(seed)));
        fr(CMD_UPD_OUT, 4'h0, 16'hFF64);
        chk_out();
        d = 16'($random(seed));
        d = d | ((d & 16'hAAAA) >> 1) | 16'h0003;
        for (int k = 0; k < NUM_CH; k++) begin
            {e_hi[k], e_lo[k]} = d[2*k+:2];
            e_hz[k] = d[2*k+1] & d[2*k];
            e_g[k] = ~d[2*k+1] & d[2*k];
        end
        fr(CMD_PWRDN, 4'h7, d);
        chk(1, 128'({e_hi, e_lo}));
        chk(5, 128'({e_hz, e_g}));
        fr(CMD_WR_UPD, 4'h0, 16'($random(seed)));
        chk_out();
        fr(CMD_CHAIN, 4'h0, 16'h0001);
        chk(2, 128'h1);
        w = {24'($random(seed)), CMD_WR_UPD, 4'h7, 16'($random(seed))};
        frx(w, 48);
        chk(4, 128'(w[47:24]));
        chk_out();
        fr(CMD_CHAIN, 4'h0, 16'h0000);
        frx({18'h0, 6'h2A, CMD_WR_UPD, 4'h1, 16'($random(seed))}, 30);
        chk_out();
        rst_n = 1'b0;
        tick(8);
        rst_n = 1'b1;
        tick(5);
        chk(2, 128'h0);
        tick(2);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
